// [pkg/lcdh_pkg.sv]
// Shared constants and types of the display RAM host port
`default_nettype none

package lcdh_pkg;

	localparam int unsigned DATA_W   = 8;
	localparam int unsigned COL_W    = 8;
	localparam int unsigned PAGE_W   = 4;
	localparam int unsigned LINE_W   = 6;
	localparam int unsigned BITCNT_W = 3;
	localparam int unsigned RAM_AW   = PAGE_W + COL_W;

	localparam logic [7:0] COL_LAST       = 8'h83;
	localparam logic [7:0] COL_LOCK_ABOVE = 8'h84;
	localparam logic [3:0] PAGE_LAST      = 4'h8;
	localparam logic [3:0] PAGE_IND       = 4'h8;
	localparam logic [7:0] IND_MASK       = 8'h01;
	localparam logic [2:0] BITCNT_LAST    = 3'h7;

	localparam logic [5:0] START_LINE_RST = 6'h00;
	localparam logic [7:0] COL_RST        = 8'h00;
	localparam logic [3:0] PAGE_RST       = 4'h0;

	// Command bytes (data/command select low on a write)
	localparam logic [7:0] CMD_MASK_LINE  = 8'hC0;
	localparam logic [7:0] CMD_START_LINE = 8'h40;
	localparam logic [7:0] CMD_MASK_NIB   = 8'hF0;
	localparam logic [7:0] CMD_PAGE       = 8'hB0;
	localparam logic [7:0] CMD_COL_HI     = 8'h10;
	localparam logic [7:0] CMD_COL_LO     = 8'h00;
	localparam logic [7:0] CMD_OUT_STATUS = 8'hC0;
	localparam logic [7:0] CMD_MASK_ADC   = 8'hFE;
	localparam logic [7:0] CMD_ADC        = 8'hA0;

	localparam int unsigned OUT_REV_BIT     = 3;
	localparam int unsigned STATUS_BUSY_BIT = 7;
	localparam int unsigned STATUS_ADC_BIT  = 6;
	localparam int unsigned SER_DATA_BIT    = 7;
	localparam int unsigned SER_CLK_BIT     = 6;

	// Internal operation time after a write or a data fetch
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned BUSY_TIME_NS  = 50;
	localparam int unsigned BUSY_CYC      =
		(BUSY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0]  BUSY_LOAD     = 2'(BUSY_CYC);

	typedef struct packed {
		logic       mode_par;
		logic       style;
		logic       cs_low_n;
		logic       cs_high;
		logic       dc;
		logic       strobe_a;
		logic       strobe_b;
		logic [7:0] data;
	} lcdh_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_LOAD = 2'b10
	} lcdh_state_t;

endpackage : lcdh_pkg

`default_nettype wire

// [rtl/lcdh_host_port.sv]
// Host access port of the display controller with on-chip display RAM
//
// Overview of operation
// - Interface select pin picks 8-bit parallel bus or serial input.
// - Serial mode gives no RAM reads; parallel lines stay released.
// - Bus style pin: high enable plus direction, low separate strobes.
// - Select and direction decode display read/write, status read, command.
// - Serial receiver: 8-bit shifter, 3-bit counter, only while selected.
// - Deselect clears shifter and counter, dropping any partial byte.
// - Serial bits MSB first, one per rising clock, byte every eighth.
// - Data/command select sampled on eighth edge chooses data or command.
// - Unselected chip releases data lines and ignores select and strobes.
// - Data read drives the holder, then refills it from RAM.
// - Data write latches the holder and stores RAM before next write.
// - Busy flag set during internal work; only status reads; flag on D7.
// - Start line loads line counter on frame change; line clock increments.
// - Column counter advances by one after each data read or write.
// - Column above 84H locks the counter until a new column is set.
// - Column advance never changes the page.
// - Segment direction setting reverses column to segment mapping.
// - Four-bit page register; page 8 indicator row holds only D0.
// - RAM is 132 columns by 65 rows: eight byte pages plus one bit.
// - Host access runs alongside refresh readout without disturbance.
// - Output status D3 reverses common scan direction.
`default_nettype none

module lcdh_host_port
	import lcdh_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       ce_i,
	input  wire logic                       interface_select_i,
	input  wire logic                       bus_style_select_i,
	input  wire logic                       chip_select_low_n_i,
	input  wire logic                       chip_select_high_i,
	input  wire logic                       data_command_select_i,
	input  wire logic                       rd_n_enable_i,
	input  wire logic                       wr_n_rw_i,
	input  wire logic [lcdh_pkg::DATA_W-1:0] data_i,
	output logic      [lcdh_pkg::DATA_W-1:0] data_o,
	output logic      [lcdh_pkg::DATA_W-1:0] data_oe_n_o,
	input  wire logic                       frame_alternation_signal_i,
	input  wire logic                       line_clock_i,
	input  wire logic [lcdh_pkg::PAGE_W-1:0] refresh_page_i,
	input  wire logic [lcdh_pkg::COL_W-1:0]  refresh_segment_i,
	output logic      [lcdh_pkg::DATA_W-1:0] refresh_data_o,
	output logic      [lcdh_pkg::LINE_W-1:0] line_address_o,
	output logic                            common_reverse_o,
	output logic                            segment_reverse_o,
	output logic                            busy_o
);

	import lcdh_pkg::*;

	typedef struct packed {
		lcdh_state_t       st;
		lcdh_pins_t        prev;
		logic [7:0]        holder;
		logic [7:0]        shift;
		logic [2:0]        cnt;
		logic [5:0]        start_line;
		logic [5:0]        line;
		logic              fr_prev;
		logic [7:0]        column;
		logic [3:0]        page;
		logic              adc;
		logic              com_rev;
		logic [1:0]        busy_cnt;
		logic              busy;
		logic              rd_ok;
		logic [7:0]        dout;
		logic [7:0]        oe_n;
		logic              ram_we;
		logic [RAM_AW-1:0] ram_addr;
		logic [7:0]        ram_wdata;
	} lcdh_state_all_t;

	lcdh_state_all_t   q;
	lcdh_state_all_t   next_q;
	lcdh_pins_t        raw;
	lcdh_pins_t        sp;
	logic [7:0]        ram_rdata;
	logic [RAM_AW-1:0] disp_addr;

	////////////////////////////////////////////////////////////////////
	// Pin capture

	assign raw = '{
		mode_par: interface_select_i,
		style:    bus_style_select_i,
		cs_low_n: chip_select_low_n_i,
		cs_high:  chip_select_high_i,
		dc:       data_command_select_i,
		strobe_a: rd_n_enable_i,
		strobe_b: wr_n_rw_i,
		data:     data_i
	};

	lcdh_sync #(
		.W($bits(lcdh_pins_t))
	) u_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.ce_i   (ce_i),
		.d_i    (raw),
		.q_o    (sp)
	);

	////////////////////////////////////////////////////////////////////
	// Access decode

	function automatic logic f_sel(input lcdh_pins_t x);
		return !x.cs_low_n && x.cs_high;
	endfunction : f_sel

	// Read level: enable high with direction high, or read strobe low
	function automatic logic f_rd(input lcdh_pins_t x);
		return f_sel(x) && x.mode_par &&
			(x.style ? (x.strobe_a && x.strobe_b) : !x.strobe_a);
	endfunction : f_rd

	function automatic logic f_wr(input lcdh_pins_t x);
		return f_sel(x) && x.mode_par &&
			(x.style ? (x.strobe_a && !x.strobe_b) : !x.strobe_b);
	endfunction : f_wr

	logic       sel;
	logic       rd_now;
	logic       rd_was;
	logic       wr_par;
	logic       ser_rise;
	logic       ser_done;
	logic [7:0] ser_byte;
	logic       wr_go;
	logic       wr_dc;
	logic [7:0] wr_byte;
	logic       accept;
	logic       col_set;
	logic       page_set;
	logic [7:0] col_adv;
	logic [7:0] status;
	logic [7:0] seg_col;

	assign sel    = f_sel(sp);
	assign rd_now = f_rd(sp);
	assign rd_was = f_rd(q.prev);
	// Data taken at strobe end, from the last sample while it was held
	assign wr_par = f_wr(q.prev) && !f_wr(sp);

	assign ser_rise = !sp.mode_par && sel && sp.data[SER_CLK_BIT] &&
		!q.prev.data[SER_CLK_BIT];
	assign ser_done = ser_rise && q.cnt == BITCNT_LAST;
	assign ser_byte = {q.shift[6:0], sp.data[SER_DATA_BIT]};

	assign wr_go   = wr_par || ser_done;
	assign wr_dc   = wr_par ? q.prev.dc : sp.dc;
	assign wr_byte = wr_par ? q.prev.data : ser_byte;
	assign accept  = wr_go && !q.busy;

	assign col_set = accept && !wr_dc &&
		(((wr_byte & CMD_MASK_NIB) == CMD_COL_HI) ||
		((wr_byte & CMD_MASK_NIB) == CMD_COL_LO));
	assign page_set = accept && !wr_dc &&
		((wr_byte & CMD_MASK_NIB) == CMD_PAGE);

	// Locked column holds still; page is never touched here
	assign col_adv = (q.column > COL_LOCK_ABOVE) ? q.column :
		q.column + 8'h01;

	always_comb begin
		status = 8'h00;
		status[STATUS_BUSY_BIT] = q.busy;
		status[STATUS_ADC_BIT]  = q.adc;
	end

	// Refresh side sees segments; direction setting flips the column
	assign seg_col   = q.adc ? (COL_LAST - refresh_segment_i) :
		refresh_segment_i;
	assign disp_addr = {refresh_page_i, seg_col};

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_q        = q;
		next_q.prev   = sp;
		next_q.ram_we = 1'b0;

		// Serial receiver
		if (!sel) begin
			next_q.shift = 8'h00;
			next_q.cnt   = 3'h0;
		end else if (ser_rise) begin
			next_q.shift = ser_byte;
			next_q.cnt   = q.cnt + 3'h1;
		end

		// Busy countdown and fetch pipeline
		if (q.busy_cnt != 2'h0) begin
			next_q.busy_cnt = q.busy_cnt - 2'h1;
		end
		case (q.st)
			ST_ADDR: begin
				next_q.st = ST_LOAD;
			end
			ST_LOAD: begin
				next_q.holder = ram_rdata;
				next_q.st     = ST_IDLE;
			end
			default: begin
				next_q.st = ST_IDLE;
			end
		endcase

		// Parallel read: drive at start, refill holder at end
		if (rd_now && !rd_was) begin
			next_q.rd_ok = sp.dc && !q.busy;
			next_q.dout  = sp.dc ? q.holder : status;
		end
		if (rd_now && (!sp.dc || next_q.rd_ok)) begin
			next_q.oe_n = 8'h00;
		end else begin
			next_q.oe_n = 8'hFF;
		end
		if (rd_was && !rd_now && q.rd_ok) begin
			next_q.rd_ok    = 1'b0;
			next_q.ram_addr = {q.page, q.column};
			next_q.st       = ST_ADDR;
			next_q.column   = col_adv;
		end

		// Writes: display data or command byte
		if (accept) begin
			next_q.busy_cnt = BUSY_LOAD;
			if (wr_dc) begin
				// Holder now owns the written byte, so the next
				// read returns it: the host's dummy read
				next_q.holder    = wr_byte;
				next_q.ram_addr  = {q.page, q.column};
				next_q.ram_wdata = (q.page == PAGE_IND) ?
					(wr_byte & IND_MASK) : wr_byte;
				next_q.ram_we    = (q.page <= PAGE_LAST) &&
					(q.column <= COL_LAST);
				next_q.column    = col_adv;
			end else if ((wr_byte & CMD_MASK_LINE) == CMD_START_LINE) begin
				next_q.start_line = wr_byte[5:0];
			end else if ((wr_byte & CMD_MASK_NIB) == CMD_PAGE) begin
				next_q.page = wr_byte[3:0];
			end else if ((wr_byte & CMD_MASK_NIB) == CMD_COL_HI) begin
				next_q.column[7:4] = wr_byte[3:0];
			end else if ((wr_byte & CMD_MASK_NIB) == CMD_COL_LO) begin
				next_q.column[3:0] = wr_byte[3:0];
			end else if ((wr_byte & CMD_MASK_ADC) == CMD_ADC) begin
				next_q.adc = wr_byte[0];
			end else if ((wr_byte & CMD_MASK_NIB) == CMD_OUT_STATUS) begin
				next_q.com_rev = wr_byte[OUT_REV_BIT];
			end
		end

		next_q.busy = (next_q.busy_cnt != 2'h0) ||
			(next_q.st != ST_IDLE);

		// Line counter for the refresh side
		next_q.fr_prev = frame_alternation_signal_i;
		if (frame_alternation_signal_i != q.fr_prev) begin
			next_q.line = q.start_line;
		end else if (line_clock_i) begin
			next_q.line = q.line + 6'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q            <= '0;
			q.st         <= ST_IDLE;
			q.start_line <= START_LINE_RST;
			q.column     <= COL_RST;
			q.page       <= PAGE_RST;
			q.oe_n       <= 8'hFF;
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Display RAM

	lcdh_ram u_ram (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.host_we_i   (q.ram_we),
		.host_addr_i (q.ram_addr),
		.host_wdata_i(q.ram_wdata),
		.host_rdata_o(ram_rdata),
		.disp_addr_i (disp_addr),
		.disp_rdata_o(refresh_data_o)
	);

	assign data_o            = q.dout;
	assign data_oe_n_o       = q.oe_n;
	assign line_address_o    = q.line;
	assign common_reverse_o  = q.com_rev;
	assign segment_reverse_o = q.adc;
	assign busy_o            = q.busy;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	unsel_release_a: assert property (
		ce_i && !sel |=> q.oe_n == 8'hFF
	) else $error("data lines driven while not selected");

	serial_no_read_a: assert property (
		ce_i && !sp.mode_par |=> q.oe_n == 8'hFF
	) else $error("data lines driven in serial mode");

	ser_clear_a: assert property (
		ce_i && !sel |=> q.cnt == 3'h0 && q.shift == 8'h00
	) else $error("serial receiver not cleared on deselect");

	ser_byte_a: assert property (
		ser_rise && q.cnt == BITCNT_LAST |-> wr_go && wr_dc == sp.dc
	) else $error("eighth serial edge did not complete a byte");

	col_lock_a: assert property (
		ce_i && q.column > COL_LOCK_ABOVE && !col_set |=> $stable(q.column)
	) else $error("locked column counter moved");

	page_keep_a: assert property (
		ce_i && !page_set |=> $stable(q.page)
	) else $error("page changed without a page command");

	line_load_a: assert property (
		ce_i && frame_alternation_signal_i != q.fr_prev
		|=> q.line == $past(q.start_line)
	) else $error("line counter not loaded on frame change");

	holder_fill_a: assert property (
		ce_i && q.st == ST_ADDR ##1 ce_i && q.st == ST_LOAD
		|=> q.holder == $past(ram_rdata) && q.st == ST_IDLE
	) else $error("holder not refilled from RAM");

	write_store_a: assert property (
		ce_i && accept && wr_dc && q.page < PAGE_IND && q.column <= COL_LAST
		|=> q.ram_we && q.holder == $past(wr_byte)
	) else $error("data write not stored");

	busy_refuse_a: assert property (
		ce_i && q.busy && wr_go |=> !q.ram_we && $stable(q.column)
	) else $error("write accepted while busy");

	seg_map_a: assert property (
		q.adc && refresh_segment_i == 8'h00 |-> disp_addr[7:0] == COL_LAST
	) else $error("segment reversal mapping wrong");

endmodule : lcdh_host_port

`default_nettype wire

// [rtl/lcdh_ram.sv]
// Dual-read display RAM: host port and refresh read port
`default_nettype none

module lcdh_ram
	import lcdh_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              host_we_i,
	input  wire logic [RAM_AW-1:0] host_addr_i,
	input  wire logic [7:0]        host_wdata_i,
	output logic      [7:0]        host_rdata_o,
	input  wire logic [RAM_AW-1:0] disp_addr_i,
	output logic      [7:0]        disp_rdata_o
);

	typedef struct packed {
		logic [7:0] host;
		logic [7:0] disp;
	} lcdh_ram_st_t;

	logic [7:0]   mem [2**RAM_AW];
	lcdh_ram_st_t q;

	// Array carries no reset; only the read registers do
	always_ff @(posedge clk_i) begin
		if (ce_i && host_we_i) begin
			mem[host_addr_i] <= host_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q.host <= mem[host_addr_i];
			q.disp <= mem[disp_addr_i];
		end
	end

	assign host_rdata_o = q.host;
	assign disp_rdata_o = q.disp;

endmodule : lcdh_ram

`default_nettype wire

// [rtl/lcdh_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none

module lcdh_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} lcdh_sync_st_t;

	lcdh_sync_st_t q;
	lcdh_sync_st_t next_q;

	always_comb begin
		next_q.s1 = d_i;
		next_q.s2 = q.s1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	assign q_o = q.s2;

endmodule : lcdh_sync

`default_nettype wire

// [verification/lcdh_host_model.sv]
// Host processor model driving the parallel bus or the serial link
`default_nettype none

module lcdh_host_model
	import lcdh_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [7:0] bus_i,
	output var  lcdh_pins_t pins_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial pins_o = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};

	////////////////////////////////////////////////////////////////////////////////
	task automatic setup(input logic par, input logic style);
		@(negedge clk_i);
		pins_o.mode_par = par;
		pins_o.style    = style;
		pins_o.strobe_a = ~style;
		pins_o.strobe_b = 1'b1;
		pins_o.data     = 8'h00;
		repeat (10) @(negedge clk_i);
	endtask : setup

	task automatic select(input logic lo_n, input logic hi);
		@(negedge clk_i);
		pins_o.cs_low_n = lo_n;
		pins_o.cs_high  = hi;
		repeat (6) @(negedge clk_i);
	endtask : select

	// Long strobe and gap cover pin sync and busy time, so no polling
	task automatic access(input logic rd, input logic dc, input logic [7:0] wv,
		output logic [7:0] rv);
		@(negedge clk_i);
		pins_o.dc       = dc;
		pins_o.data     = rd ? ~pins_o.data : wv;
		pins_o.strobe_b = pins_o.style ? rd : 1'b1;
		@(negedge clk_i);
		if (pins_o.style) begin
			pins_o.strobe_a = 1'b1;
		end else begin
			pins_o.strobe_a = ~rd;
			pins_o.strobe_b = rd;
		end
		repeat (6) @(posedge clk_i);
		rv = bus_i;
		@(negedge clk_i);
		pins_o.strobe_a = ~pins_o.style;
		pins_o.strobe_b = 1'b1;
		repeat (2) @(negedge clk_i);
		pins_o.data = ~pins_o.data;
		repeat (12) @(negedge clk_i);
	endtask : access

	// Two data writes in separate-strobe style; the second release
	// falls two cycles after the first is taken, while still busy
	task automatic burst(input logic [7:0] a, input logic [7:0] b);
		@(negedge clk_i);
		pins_o.dc       = 1'b1;
		pins_o.data     = a;
		pins_o.strobe_b = 1'b0;
		repeat (4) @(negedge clk_i);
		pins_o.data     = b;
		pins_o.strobe_b = 1'b1;
		@(negedge clk_i);
		pins_o.strobe_b = 1'b0;
		@(negedge clk_i);
		pins_o.strobe_b = 1'b1;
		repeat (12) @(negedge clk_i);
	endtask : burst

	// Serial clock idles low between frames
	task automatic shift(input logic dc, input logic [7:0] b, input int n);
		@(negedge clk_i);
		pins_o.dc = dc;
		for (int i = 7; i > 7 - n; i--) begin
			pins_o.data[SER_DATA_BIT] = b[i];
			repeat (4) @(negedge clk_i);
			pins_o.data[SER_CLK_BIT] = 1'b1;
			repeat (4) @(negedge clk_i);
			pins_o.data[SER_CLK_BIT] = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		pins_o.data[SER_DATA_BIT] = ~pins_o.data[SER_DATA_BIT];
		repeat (8) @(negedge clk_i);
	endtask : shift

endmodule : lcdh_host_model

`default_nettype wire

// [verification/lcdh_host_port_bench.sv]
// Self-checking bench for the display RAM host port
`default_nettype none

module lcdh_host_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lcdh_pkg::*;

	logic       clk       = 1'b0;
	logic       rst_n     = 1'b0;
	logic       frame     = 1'b0;
	logic       lclk      = 1'b0;
	logic [3:0] rpage     = 4'h0;
	logic [7:0] rseg      = 8'h00;
	logic       busy_seen = 1'b0;
	logic       drv_seen  = 1'b0;
	int         fail_count = 0;
	int         n_tests    = 0;
	lcdh_pins_t pins;
	wire logic [7:0] bus;
	logic [7:0] dout, oe_n, rdat, rv, v;
	logic [5:0] line;
	logic       com_rev, seg_rev, busy;

	always #12.5 clk = ~clk;
	assign bus = (~oe_n & dout) | (oe_n & pins.data);

	always @(posedge clk) begin
		if (busy === 1'b1) busy_seen = 1'b1;
		if (oe_n !== 8'hFF) drv_seen = 1'b1;
	end

	lcdh_host_model u_host (.clk_i(clk), .bus_i(bus), .pins_o(pins));

	lcdh_host_port u_dut (
		.clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
		.interface_select_i(pins.mode_par), .bus_style_select_i(pins.style),
		.chip_select_low_n_i(pins.cs_low_n), .chip_select_high_i(pins.cs_high),
		.data_command_select_i(pins.dc), .rd_n_enable_i(pins.strobe_a),
		.wr_n_rw_i(pins.strobe_b), .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n),
		.frame_alternation_signal_i(frame), .line_clock_i(lclk),
		.refresh_page_i(rpage), .refresh_segment_i(rseg), .refresh_data_o(rdat),
		.line_address_o(line), .common_reverse_o(com_rev),
		.segment_reverse_o(seg_rev), .busy_o(busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] b);
		u_host.access(1'b0, 1'b0, b, rv);
	endtask : cmd

	task automatic wd(input logic [7:0] b);
		u_host.access(1'b0, 1'b1, b, rv);
	endtask : wd

	task automatic at(input logic [3:0] pg, input logic [7:0] col);
		cmd(CMD_PAGE | {4'h0, pg});
		cmd(CMD_COL_HI | {4'h0, col[7:4]});
		cmd(CMD_COL_LO | {4'h0, col[3:0]});
	endtask : at

	task automatic rd_at(input logic [3:0] pg, input logic [7:0] col, input logic [7:0] e,
		input string m);
		at(pg, col);
		u_host.access(1'b1, 1'b1, 8'h00, v);
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk(v, e, m);
	endtask : rd_at

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_par();
		at(4'h0, 8'h00);
		busy_seen = 1'b0;
		wd(8'hA5);
		chk({7'h0, busy_seen}, 8'h01, "busy after write");
		wd(8'h3C);
		u_host.access(1'b1, 1'b0, 8'h00, v);
		chk(v, 8'h00, "idle status");
		rd_at(4'h0, 8'h00, 8'hA5, "first byte");
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk(v, 8'h3C, "next column");
		$display("test separate strobes done");
	endtask : t_par

	// Second strobe ends inside the busy time, so it must be dropped
	task automatic t_busy();
		at(4'h0, 8'h11);
		wd(8'h33);
		at(4'h0, 8'h10);
		u_host.burst(8'hC5, 8'h3A);
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk(v, 8'hC5, "write refused while busy");
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk(v, 8'h33, "column held while busy");
		$display("test busy refusal done");
	endtask : t_busy

	task automatic t_style();
		u_host.setup(1'b1, 1'b1);
		at(4'h0, 8'h02);
		wd(8'h5A);
		wd(8'h6B);
		rd_at(4'h0, 8'h02, 8'h5A, "enable style");
		u_host.setup(1'b1, 1'b0);
		$display("test enable strobe done");
	endtask : t_style

	task automatic t_page();
		at(4'h8, 8'h05);
		wd(8'hFF);
		rd_at(4'h8, 8'h05, 8'h01, "indicator row");
		at(4'h2, 8'h00);
		wd(8'hC3);
		at(4'h1, 8'h83);
		wd(8'h77);
		wd(8'h99);
		rd_at(4'h2, 8'h00, 8'hC3, "page kept");
		rd_at(4'h1, 8'h83, 8'h77, "last column");
		$display("test pages done");
	endtask : t_page

	task automatic t_refresh();
		rpage = 4'h0;
		rseg  = 8'h00;
		repeat (2) @(negedge clk);
		chk(rdat, 8'hA5, "refresh plain");
		cmd(CMD_ADC | 8'h01);
		chk({7'h0, seg_rev}, 8'h01, "segment reverse");
		rseg = COL_LAST;
		repeat (2) @(negedge clk);
		chk(rdat, 8'hA5, "refresh reversed");
		u_host.access(1'b1, 1'b0, 8'h00, v);
		chk(v, 8'h40, "status direction");
		cmd(CMD_ADC);
		$display("test refresh done");
	endtask : t_refresh

	task automatic t_line();
		cmd(CMD_START_LINE | 8'h15);
		frame = ~frame;
		repeat (2) @(negedge clk);
		chk({2'b00, line}, 8'h15, "line preset");
		lclk = 1'b1;
		@(negedge clk);
		lclk = 1'b0;
		@(negedge clk);
		chk({2'b00, line}, 8'h16, "line step");
		cmd(CMD_OUT_STATUS | 8'h08);
		chk({7'h0, com_rev}, 8'h01, "common reverse");
		cmd(CMD_OUT_STATUS);
		chk({7'h0, com_rev}, 8'h00, "common normal");
		$display("test line counter done");
	endtask : t_line

	task automatic t_desel();
		u_host.select(1'b1, 1'b1);
		drv_seen = 1'b0;
		at(4'h0, 8'h00);
		wd(8'h11);
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk({7'h0, drv_seen}, 8'h00, "pins released");
		u_host.select(1'b0, 1'b1);
		rd_at(4'h0, 8'h00, 8'hA5, "write ignored");
		$display("test deselect done");
	endtask : t_desel

	task automatic t_serial();
		u_host.setup(1'b0, 1'b0);
		drv_seen = 1'b0;
		u_host.shift(1'b0, CMD_PAGE, 8);
		u_host.shift(1'b0, CMD_COL_HI, 8);
		u_host.shift(1'b0, 8'h04, 8);
		u_host.shift(1'b1, 8'hF0, 3);
		u_host.select(1'b0, 1'b0);
		u_host.select(1'b0, 1'b1);
		u_host.shift(1'b1, 8'h96, 8);
		u_host.shift(1'b1, 8'h69, 8);
		chk({7'h0, drv_seen}, 8'h00, "serial never drives");
		u_host.setup(1'b1, 1'b0);
		rd_at(4'h0, 8'h04, 8'h96, "serial first");
		u_host.access(1'b1, 1'b1, 8'h00, v);
		chk(v, 8'h69, "serial second");
		$display("test serial done");
	endtask : t_serial

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_par();
		t_busy();
		t_style();
		t_page();
		t_refresh();
		t_line();
		t_desel();
		t_serial();
		end_sim();
	end

	// Tests need about 2300 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim();
	end

endmodule : lcdh_host_port_bench

`default_nettype wire
